// >>> verification/dcwd_apb_host.sv
// APB host model that writes synthesizer words to the decoder
`timescale 1ns/1ps
module dcwd_apb_host
	import dcwd_pkg::*;
(
	input wire logic clk,
	input wire logic pready,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
	end

	// Random idle gap so the slave also sees a slow host
	task automatic xfer(input logic we, input logic [7:0] a,
		input logic [31:0] d);
		repeat ($urandom_range(0, 2)) @(posedge clk);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= we;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic word(input logic [15:0] w);
		logic [15:0] v;
		v = w;
		if (w[15:14] == DCWD_TGT_CTRL) v = w & 16'hFFFA;
		xfer(1'b1, DCWD_OFF_WORD, {16'h0000, v});
	endtask

	// Low half first, high half second, same target
	task automatic freq28(input logic [1:0] tgt, input logic [27:0] f);
		word({tgt, f[13:0]});
		word({tgt, f[27:14]});
	endtask
endmodule

// >>> verification/tb_top.sv
// Self-checking bench for the control word decoder
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin \
	failures++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb_top;
	import dcwd_pkg::*;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic freq_choose_pin = 1'b0;
	logic phase_choose_pin = 1'b0;
	logic acc_reset_pin = 1'b0;
	logic sleep_pin = 1'b0;
	logic comparator_in = 1'b0;
	logic [DCWD_DAC_W-1:0] dac_code, held;
	logic dac_powerdown, square_out, square_oe, prev;
	logic [32:0] exp_q[$];
	logic [32:0] e;
	int failures = 0;
	int n_compared = 0;
	int cycles = 0;
	int cnt;

	dcwd_top dut (.clk(clk), .arst_n(arst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .freq_choose_pin(freq_choose_pin),
		.phase_choose_pin(phase_choose_pin),
		.acc_reset_pin(acc_reset_pin), .sleep_pin(sleep_pin),
		.comparator_in(comparator_in), .dac_code(dac_code),
		.dac_powerdown(dac_powerdown), .square_out(square_out),
		.square_oe(square_oe));
	dcwd_apb_host host (.clk(clk), .pready(pready), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata));

	always #50 clk = ~clk;

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			stop_test();
		end
	end

	// Read answers are matched against the oldest expectation
	always @(posedge clk) begin
		if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
			e = exp_q.pop_front();
			`CHK("read", e, {pslverr, prdata})
		end
	end

	task automatic stop_test();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic rd(input logic [7:0] a, input logic [32:0] x);
		exp_q.push_back(x);
		host.xfer(1'b0, a, 32'h0000_0000);
	endtask

	// Outputs follow one edge after the control word lands
	task automatic ctl(input int bits);
		host.word(16'(bits));
		@(posedge clk);
		#1;
	endtask

	task automatic count_sq(input int exp_n);
		repeat (4) @(posedge clk);
		#1;
		prev = square_out;
		cnt = 0;
		repeat (64) begin
			@(posedge clk);
			#1;
			if (square_out !== prev) cnt++;
			prev = square_out;
		end
		`CHK("toggles", exp_n, cnt)
	endtask

	initial begin
		void'($urandom(95931));
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		#1;
		`CHK("oe", 1'b0, square_oe)
		`CHK("dac", 10'h200, dac_code)
		rd(DCWD_OFF_CTRL, 33'h0_0000_0000);
		host.word(16'h0047);
		#1;
		`CHK("pd early", 1'b0, dac_powerdown)
		@(posedge clk);
		#1;
		`CHK("pd", 1'b1, dac_powerdown)
		rd(DCWD_OFF_CTRL, 33'h0_0000_0042);
		ctl(1 << DCWD_B_HALF);
		host.word(16'h5000);
		rd(DCWD_OFF_FREQ0, 33'h0_0400_0000);
		ctl(1 << DCWD_B_RST);
		repeat (5) @(posedge clk);
		rd(DCWD_OFF_STATUS, 33'h0_0000_2000);
		#1;
		`CHK("mid", 10'h200, dac_code)
		ctl((1 << DCWD_B_RST) | (1 << DCWD_B_MODE));
		`CHK("mid ramp", 10'h200, dac_code)
		ctl(1 << DCWD_B_MODE);
		repeat (3) @(posedge clk);
		#1;
		held = dac_code;
		@(posedge clk);
		#1;
		// Ramp climbs by a quarter of the phase step of freq0 every cycle
		`CHK("ramp", 10'h100, 10'(dac_code - held))
		ctl(0);
		repeat (3) @(posedge clk);
		#1;
		held = dac_code;
		@(posedge clk);
		#1;
		`CHK("sine", 1'b1, held !== 10'h200 || dac_code !== 10'h200)
		ctl(1 << DCWD_B_HALT);
		held = dac_code;
		repeat (10) @(posedge clk);
		#1;
		`CHK("halt", held, dac_code)
		ctl((1 << DCWD_B_MSBEN) | (1 << DCWD_B_BYP));
		`CHK("oe on", 1'b1, square_oe)
		count_sq(32);
		ctl(1 << DCWD_B_MSBEN);
		count_sq(16);
		ctl((1 << DCWD_B_MSBEN) | (1 << DCWD_B_SQSRC));
		repeat (4) begin
			@(posedge clk);
			comparator_in <= 1'($urandom_range(0, 1));
			repeat (3) @(posedge clk);
			#1;
			`CHK("cmp", comparator_in, square_out)
		end
		ctl(0);
		`CHK("oe off", 1'b0, square_oe)
		ctl(1 << DCWD_B_SRC);
		@(posedge clk);
		acc_reset_pin <= 1'b1;
		sleep_pin <= 1'b1;
		freq_choose_pin <= 1'b1;
		phase_choose_pin <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		`CHK("sleep", 1'b1, dac_powerdown)
		rd(DCWD_OFF_STATUS, 33'h0_0003_E000);
		@(posedge clk);
		acc_reset_pin <= 1'b0;
		sleep_pin <= 1'b0;
		freq_choose_pin <= 1'b0;
		phase_choose_pin <= 1'b0;
		ctl(1 << DCWD_B_FULL);
		host.freq28(DCWD_TGT_F0, 28'h000_8001);
		rd(DCWD_OFF_FREQ0, 33'h0_0000_8001);
		ctl(0);
		host.word(16'h8005);
		rd(DCWD_OFF_FREQ1, 33'h0_0000_0005);
		host.word(16'hC123);
		host.word(16'hE456);
		rd(DCWD_OFF_PHASE, 33'h0_0456_0123);
		rd(8'h20, 33'h1_0000_0000);
		repeat (2) @(posedge clk);
		stop_test();
	end
endmodule

// >>> verilog/dcwd_phase_amp.sv
// Phase to amplitude conversion: quarter sine table or ramp bypass
`timescale 1ns/1ps
module dcwd_phase_amp
	import dcwd_pkg::*;
(
	input wire logic [dcwd_pkg::DCWD_PHASE_W-1:0] phase,
	input wire logic ramp_mode,
	output logic [dcwd_pkg::DCWD_DAC_W-1:0] amp
);
	// ----------------------------------------
	// Quarter wave table
	// ----------------------------------------
	// Coarse 16 entry table keeps area small at the cost of purity
	localparam logic [8:0] SINE_ROM [16] = '{
		9'h019, 9'h04B, 9'h07C, 9'h0AC, 9'h0DB, 9'h107, 9'h130, 9'h157,
		9'h17B, 9'h19A, 9'h1B6, 9'h1CE, 9'h1E1, 9'h1F0, 9'h1F9, 9'h1FE
	};

	logic [3:0] idx;
	logic [8:0] mag;

	always_comb begin
		idx = phase[9:6];
		if (phase[10]) begin
			idx = ~phase[9:6];
		end
		mag = SINE_ROM[idx];
		if (ramp_mode) begin
			amp = phase[11:2];
		end else if (phase[11]) begin
			amp = DCWD_DAC_MID - {1'b0, mag};
		end else begin
			amp = DCWD_DAC_MID + {1'b0, mag};
		end
	end
endmodule

// >>> verilog/dcwd_pkg.sv
// Constants shared by the synthesizer control word decoder
package dcwd_pkg;
	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] DCWD_OFF_WORD = 8'h00;
	localparam logic [7:0] DCWD_OFF_CTRL = 8'h04;
	localparam logic [7:0] DCWD_OFF_FREQ0 = 8'h08;
	localparam logic [7:0] DCWD_OFF_FREQ1 = 8'h0C;
	localparam logic [7:0] DCWD_OFF_PHASE = 8'h10;
	localparam logic [7:0] DCWD_OFF_STATUS = 8'h14;

	// ----------------------------------------
	// Widths and reset values
	// ----------------------------------------
	localparam int DCWD_FREQ_W = 28;
	localparam int DCWD_HALF_W = 14;
	localparam int DCWD_PHASE_W = 12;
	localparam int DCWD_DAC_W = 10;
	localparam logic [15:0] DCWD_CTRL_RESET = 16'h0000;
	localparam logic [15:0] DCWD_CTRL_WMASK = 16'h3FFA;
	localparam logic [9:0] DCWD_DAC_MID = 10'h200;

	// ----------------------------------------
	// Word target field and control bit positions
	// ----------------------------------------
	localparam int DCWD_TGT_HI = 15;
	localparam int DCWD_TGT_LO = 14;
	localparam logic [1:0] DCWD_TGT_CTRL = 2'b00;
	localparam logic [1:0] DCWD_TGT_F0 = 2'b01;
	localparam logic [1:0] DCWD_TGT_F1 = 2'b10;
	localparam logic [1:0] DCWD_TGT_PH = 2'b11;
	localparam int DCWD_PH_SEL_BIT = 13;
	localparam int DCWD_B_FULL = 13;
	localparam int DCWD_B_HALF = 12;
	localparam int DCWD_B_FREQ_REG_SELECT = 11;
	localparam int DCWD_B_PSEL = 10;
	localparam int DCWD_B_SRC = 9;
	localparam int DCWD_B_RST = 8;
	localparam int DCWD_B_HALT = 7;
	localparam int DCWD_B_PD = 6;
	localparam int DCWD_B_MSBEN = 5;
	localparam int DCWD_B_SQSRC = 4;
	localparam int DCWD_B_BYP = 3;
	localparam int DCWD_B_MODE = 1;
endpackage

// >>> verilog/dcwd_top.sv
// Control word decoder and synthesis core behind an APB slave
// Contract
// - Source bit 1: select, reset and sleep come from the pins.
// - Reset bit 1 forces the accumulator to zero, midscale output.
// - Accumulator stays cleared while reset bit is 1.
// - Clock halt freezes accumulator and converter output.
// - Power-down bit powers the converter down.
// - MSB enable routes accumulator MSB, direct or halved, to square pin.
// - MSB enable 0: square pin not driven.
// - Square source 0: pin carries MSB, divided by one or two.
// - Square source 1: pin carries comparator output.
// - Bypass bit 0: MSB square wave divided by two.
// - Bypass bit 1: MSB passed straight through.
// - Mode 0, not halted: sine table drives the converter.
// - Mode 1, not halted: phase drives converter directly, a ramp.
// - Source bit picks register bits or pins for four functions.
// - Full-word load: two writes, low 14 bits then high 14 bits.
// - Half load: one 14-bit write to half chosen by half select.
// - Top two word bits: 01/10 frequency, 11 phase, 00 control.
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module dcwd_top
	import dcwd_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic freq_choose_pin,
	input wire logic phase_choose_pin,
	input wire logic acc_reset_pin,
	input wire logic sleep_pin,
	input wire logic comparator_in,
	output logic [dcwd_pkg::DCWD_DAC_W-1:0] dac_code,
	output logic dac_powerdown,
	output logic square_out,
	output logic square_oe
);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic pick(input logic src, input logic pin,
		input logic bitv);
		return src ? pin : bitv;
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		return (a == DCWD_OFF_WORD) || (a == DCWD_OFF_CTRL) ||
			(a == DCWD_OFF_FREQ0) || (a == DCWD_OFF_FREQ1) ||
			(a == DCWD_OFF_PHASE) || (a == DCWD_OFF_STATUS);
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [15:0] ctrl_q, ctrl_d;
	logic [27:0] freq0_q, freq0_d, freq1_q, freq1_d, acc_q, acc_d;
	logic [11:0] phase0_q, phase0_d, phase1_q, phase1_d;
	logic [13:0] stage_q, stage_d;
	logic half_pend_q, half_pend_d;
	logic [9:0] dac_q, dac_d;
	logic pd_q, pd_d, sq_q, sq_d, oe_q, oe_d;
	logic msb_prev_q, msb_prev_d, div2_q, div2_d;
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pready_d, pslverr_q, pslverr_d;

	logic src, rst_eff, halt_eff, pd_eff, freq_reg_select_eff, psel_eff;
	logic wr_word, msb;
	logic [15:0] w;
	logic [11:0] phase;
	logic [9:0] amp;

	// ----------------------------------------
	// Effective controls
	// ----------------------------------------
	always_comb begin
		src = ctrl_q[DCWD_B_SRC];
		rst_eff = pick(src, acc_reset_pin, ctrl_q[DCWD_B_RST]);
		pd_eff = pick(src, sleep_pin, ctrl_q[DCWD_B_PD]);
		freq_reg_select_eff = pick(src, freq_choose_pin, ctrl_q[DCWD_B_FREQ_REG_SELECT]);
		psel_eff = pick(src, phase_choose_pin, ctrl_q[DCWD_B_PSEL]);
		// Sleep pin also stops the clocks, as the pin form of sleep does
		halt_eff = ctrl_q[DCWD_B_HALT] | (src & sleep_pin);
		msb = acc_q[DCWD_FREQ_W-1];
		phase = acc_q[27:16] + (psel_eff ? phase1_q : phase0_q);
	end

	dcwd_phase_amp u_amp (
		.phase(phase),
		.ramp_mode(ctrl_q[DCWD_B_MODE]),
		.amp(amp)
	);

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	// Zero wait states: pready is raised by the setup cycle
	always_comb begin
		pready_d = psel & ~penable;
		pslverr_d = 1'b0;
		prdata_d = 32'h0000_0000;
		if (psel && !penable) begin
			pslverr_d = ~mapped(paddr);
			if (pwrite) begin
				prdata_d = 32'h0000_0000;
			end else if (paddr == DCWD_OFF_CTRL) begin
				prdata_d = {16'h0000, ctrl_q};
			end else if (paddr == DCWD_OFF_FREQ0) begin
				prdata_d = {4'h0, freq0_q};
			end else if (paddr == DCWD_OFF_FREQ1) begin
				prdata_d = {4'h0, freq1_q};
			end else if (paddr == DCWD_OFF_PHASE) begin
				prdata_d = {4'h0, phase1_q, 4'h0, phase0_q};
			end else if (paddr == DCWD_OFF_STATUS) begin
				prdata_d = {13'h0000, half_pend_q, psel_eff, freq_reg_select_eff,
					pd_eff, halt_eff, rst_eff, 1'b0, phase};
			end
		end
	end

	// ----------------------------------------
	// Word decode
	// ----------------------------------------
	always_comb begin
		w = pwdata[15:0];
		wr_word = psel & penable & pwrite & pready_q & ~pslverr_q &
			(paddr == DCWD_OFF_WORD);
		ctrl_d = ctrl_q;
		freq0_d = freq0_q;
		freq1_d = freq1_q;
		phase0_d = phase0_q;
		phase1_d = phase1_q;
		stage_d = stage_q;
		half_pend_d = half_pend_q;
		if (wr_word) begin
			case (w[DCWD_TGT_HI:DCWD_TGT_LO])
				DCWD_TGT_CTRL: begin
					// Reserved bits are dropped even if the host errs
					ctrl_d = w & DCWD_CTRL_WMASK;
					half_pend_d = 1'b0;
				end
				DCWD_TGT_PH: begin
					if (w[DCWD_PH_SEL_BIT]) begin
						phase1_d = w[11:0];
					end else begin
						phase0_d = w[11:0];
					end
				end
				default: begin
					if (ctrl_q[DCWD_B_FULL] && !half_pend_q) begin
						stage_d = w[13:0];
						half_pend_d = 1'b1;
					end else if (ctrl_q[DCWD_B_FULL]) begin
						half_pend_d = 1'b0;
						if (w[DCWD_TGT_LO]) begin
							freq0_d = {w[13:0], stage_q};
						end else begin
							freq1_d = {w[13:0], stage_q};
						end
					end else if (w[DCWD_TGT_LO]) begin
						freq0_d = ctrl_q[DCWD_B_HALF] ?
							{w[13:0], freq0_q[13:0]} :
							{freq0_q[27:14], w[13:0]};
					end else begin
						freq1_d = ctrl_q[DCWD_B_HALF] ?
							{w[13:0], freq1_q[13:0]} :
							{freq1_q[27:14], w[13:0]};
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// Accumulator and outputs
	// ----------------------------------------
	always_comb begin
		acc_d = acc_q;
		if (rst_eff) begin
			acc_d = 28'h000_0000;
		end else if (!halt_eff) begin
			acc_d = acc_q + (freq_reg_select_eff ? freq1_q : freq0_q);
		end
		// Reset forces midscale whatever the phase offset or mode
		if (rst_eff) begin
			dac_d = DCWD_DAC_MID;
		end else begin
			dac_d = halt_eff ? dac_q : amp;
		end
		pd_d = pd_eff;
		msb_prev_d = msb;
		div2_d = div2_q;
		if (rst_eff) begin
			div2_d = 1'b0;
		end else if (msb && !msb_prev_q) begin
			div2_d = ~div2_q;
		end
		oe_d = ctrl_q[DCWD_B_MSBEN];
		if (!ctrl_q[DCWD_B_MSBEN]) begin
			sq_d = 1'b0;
		end else if (ctrl_q[DCWD_B_SQSRC]) begin
			sq_d = comparator_in;
		end else if (ctrl_q[DCWD_B_BYP]) begin
			sq_d = msb;
		end else begin
			sq_d = div2_q;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_q <= DCWD_CTRL_RESET;
			freq0_q <= 28'h000_0000;
			freq1_q <= 28'h000_0000;
			phase0_q <= 12'h000;
			phase1_q <= 12'h000;
			stage_q <= 14'h0000;
			half_pend_q <= 1'b0;
			acc_q <= 28'h000_0000;
			dac_q <= DCWD_DAC_MID;
			pd_q <= 1'b0;
			sq_q <= 1'b0;
			oe_q <= 1'b0;
			msb_prev_q <= 1'b0;
			div2_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			freq0_q <= freq0_d;
			freq1_q <= freq1_d;
			phase0_q <= phase0_d;
			phase1_q <= phase1_d;
			stage_q <= stage_d;
			half_pend_q <= half_pend_d;
			acc_q <= acc_d;
			dac_q <= dac_d;
			pd_q <= pd_d;
			sq_q <= sq_d;
			oe_q <= oe_d;
			msb_prev_q <= msb_prev_d;
			div2_q <= div2_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign dac_code = dac_q;
	assign dac_powerdown = pd_q;
	assign square_out = sq_q;
	assign square_oe = oe_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	sequence s_ctrl_write;
		wr_word && (w[15:14] == DCWD_TGT_CTRL);
	endsequence

	sequence s_full_pair;
		wr_word && w[15:14] == DCWD_TGT_F0 && ctrl_q[DCWD_B_FULL] &&
			!half_pend_q ##1 wr_word && w[15:14] == DCWD_TGT_F0 &&
			ctrl_q[DCWD_B_FULL];
	endsequence

	property p_ctrl_load;
		s_ctrl_write |=> ctrl_q == ($past(pwdata[15:0]) & DCWD_CTRL_WMASK);
	endproperty
	a_ctrl_load: assert property (p_ctrl_load)
		else $error("control word not captured");

	property p_reserved;
		ctrl_q[2] == 1'b0 && ctrl_q[0] == 1'b0;
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved control bit set");

	property p_rst_clear;
		rst_eff |=> acc_q == 28'h000_0000;
	endproperty
	a_rst_clear: assert property (p_rst_clear)
		else $error("accumulator not cleared");

	property p_rst_hold;
		rst_eff [*3] |=> acc_q == 28'h000_0000 && $stable(acc_q);
	endproperty
	a_rst_hold: assert property (p_rst_hold)
		else $error("accumulator left reset early");

	property p_pin_src;
		src && acc_reset_pin |=> acc_q == 28'h000_0000;
	endproperty
	a_pin_src: assert property (p_pin_src)
		else $error("reset pin ignored");

	property p_halt;
		halt_eff && !rst_eff |=> $stable(acc_q) && $stable(dac_q);
	endproperty
	a_halt: assert property (p_halt)
		else $error("halt did not freeze");

	property p_pd;
		1'b1 |=> dac_powerdown == $past(pd_eff);
	endproperty
	a_pd: assert property (p_pd)
		else $error("power-down not applied");

	property p_no_drive;
		!ctrl_q[DCWD_B_MSBEN] |=> !square_oe && !square_out;
	endproperty
	a_no_drive: assert property (p_no_drive)
		else $error("square pin driven while disabled");

	property p_comp;
		ctrl_q[DCWD_B_MSBEN] && ctrl_q[DCWD_B_SQSRC]
			|=> square_oe && square_out == $past(comparator_in);
	endproperty
	a_comp: assert property (p_comp)
		else $error("comparator not routed");

	property p_direct;
		ctrl_q[DCWD_B_MSBEN] && !ctrl_q[DCWD_B_SQSRC] && ctrl_q[DCWD_B_BYP]
			|=> square_out == $past(msb);
	endproperty
	a_direct: assert property (p_direct)
		else $error("msb not passed directly");

	property p_div2;
		ctrl_q[DCWD_B_MSBEN] && !ctrl_q[DCWD_B_SQSRC] &&
			!ctrl_q[DCWD_B_BYP] && !rst_eff && msb && !msb_prev_q
			|=> ##1 square_out != $past(square_out);
	endproperty
	a_div2: assert property (p_div2)
		else $error("halved square did not toggle");

	property p_ramp;
		ctrl_q[DCWD_B_MODE] && !halt_eff && !rst_eff
			|=> dac_code == $past(phase[11:2]);
	endproperty
	a_ramp: assert property (p_ramp)
		else $error("ramp output wrong");

	property p_full;
		s_full_pair |=> freq0_q == {$past(w[13:0]), $past(w[13:0], 2)};
	endproperty
	a_full: assert property (p_full)
		else $error("full-word load wrong");
endmodule
